// ==== logic/alevt_defs.svh ====
// Purpose: Offsets, field positions and reset values of the event block
// Assumes: Byte addresses on an 8-bit Wishbone address, one word each
// Notes:   Definitions only, no logic
`ifndef ALEVT_DEFS_SVH
`define ALEVT_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ALEVT_OFS_CODEC_STATUS   8'h00
`define ALEVT_OFS_CODEC_IRQ_EN   8'h04
`define ALEVT_OFS_FIRST_STATUS   8'h08
`define ALEVT_OFS_FIRST_MODE     8'h0c
`define ALEVT_OFS_SECOND_STATUS  8'h10
`define ALEVT_OFS_SECOND_MODE    8'h14
`define ALEVT_OFS_GLOBAL_STATUS  8'h18
`define ALEVT_OFS_IRQ_SET        8'h1c
`define ALEVT_OFS_IRQ_CLEAR      8'h20
`define ALEVT_OFS_IRQ_VIEW       8'h24
`define ALEVT_OFS_CONTROL        8'h28

// ----------------------------------------------------------------------
// Channel status and enable bit positions
// ----------------------------------------------------------------------
`define ALEVT_BIT_TX_FREE        0
`define ALEVT_BIT_TX_SENT        1
`define ALEVT_BIT_TX_STARVED     2
`define ALEVT_BIT_RX_FULL        4
`define ALEVT_BIT_RX_OVER        5
`define ALEVT_BIT_TX_CNT_DONE    10
`define ALEVT_BIT_TX_BUFS_EX     11
`define ALEVT_BIT_RX_CNT_DONE    14
`define ALEVT_BIT_RX_BUFS_EX     15
`define ALEVT_BIT_DMA_ROUTE      22

// ----------------------------------------------------------------------
// Global status, mask and control bit positions
// ----------------------------------------------------------------------
`define ALEVT_BIT_SOF            0
`define ALEVT_BIT_WAKE           1
`define ALEVT_BIT_CODEC_EVT      2
`define ALEVT_BIT_FIRST_EVT      3
`define ALEVT_BIT_SECOND_EVT     4
`define ALEVT_BIT_VRS            0

// ----------------------------------------------------------------------
// Writable field masks and reset values
// ----------------------------------------------------------------------
`define ALEVT_MASK_BASIC_EN      32'h0000_0037
`define ALEVT_MASK_FIRST_MODE    32'h0040_cc37
`define ALEVT_MASK_GLOBAL        32'h0000_001f
`define ALEVT_MASK_CONTROL       32'h0000_0001
`define ALEVT_RST_MODE           32'h0000_0000
`define ALEVT_RST_MASK           5'h00
`define ALEVT_RST_CONTROL        1'h0

`endif

// ==== logic/alevt_pkg.sv ====
// Purpose: Types shared by the event block files
// Assumes: Constants live in alevt_defs.svh
// Notes:   Register selector decoded from the bus address
package alevt_pkg;

    // Decoded register selector
    typedef enum logic [3:0] {
        ALEVT_SEL_NONE,
        ALEVT_SEL_STATUS,
        ALEVT_SEL_MODE,
        ALEVT_SEL_GLOBAL,
        ALEVT_SEL_SET,
        ALEVT_SEL_CLEAR,
        ALEVT_SEL_VIEW,
        ALEVT_SEL_CONTROL
    } alevt_reg_t;

    // Five global events, one bit each
    typedef logic [4:0] alevt_evt_t;

endpackage : alevt_pkg

// ==== logic/alevt_wb_slave.sv ====
// Purpose: Classic Wishbone slave front end, one wait state per access
// Assumes: Master holds the request until it samples ack
// Notes:   Side effects fire on the go pulse, one cycle before ack
`timescale 1ns/10ps
module alevt_wb_slave
    import alevt_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Wishbone request
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    input  wire logic [3:0]  sel,
    // Read data offered by the register file
    input  wire logic [31:0] rd_data,
    // Wishbone answer
    output logic             ack,
    output logic [31:0]      dat_r,
    // Access strobes towards the register file
    output logic             wr_go,
    output logic             rd_go,
    output logic [31:0]      wmask
);

    logic        ack_r;     // Answer flag
    logic        ack_nxt;
    logic [31:0] dat_r_r;   // Captured read data
    logic [31:0] dat_nxt;
    logic        go;        // New request, seen once

    // ------------------------------------------------------------------
    // Strobes and next values
    // ------------------------------------------------------------------
    // Gating on ack_r keeps a held request from firing twice
    assign go    = cyc & stb & ~ack_r;
    assign wr_go = go & we;
    assign rd_go = go & ~we;
    assign wmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};

    always_comb begin
        ack_nxt = go;
        dat_nxt = dat_r_r;
        if (rd_go) begin
            dat_nxt = rd_data;
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_r   <= 1'b0;
            dat_r_r <= 32'h0000_0000;
        end else begin
            ack_r   <= ack_nxt;
            dat_r_r <= dat_nxt;
        end
    end

    assign ack   = ack_r;
    assign dat_r = dat_r_r;

endmodule : alevt_wb_slave

// ==== logic/alevt_chan_flags.sv ====
// Purpose: Status flags of one audio channel
// Assumes: Event inputs synchronous to clk, sticky inputs are pulses
// Notes:   Transfer-count flags exist only when HAS_DMA is set
`timescale 1ns/10ps
`include "alevt_defs.svh"
module alevt_chan_flags
    import alevt_pkg::*;
#(
    parameter bit HAS_DMA = 1'b0
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Data path levels and pulses
    input  wire logic        tx_free,
    input  wire logic        tx_sent,
    input  wire logic        tx_starve,
    input  wire logic        rx_full,
    input  wire logic        rx_over,
    input  wire logic        rx_cnt_done,
    input  wire logic        rx_bufs_ex,
    input  wire logic        tx_cnt_done,
    input  wire logic        tx_bufs_ex,
    // Control
    input  wire logic        var_rate,
    input  wire logic        dma_en,
    input  wire logic        rd_clear,
    // Status word
    output logic [31:0]      status
);

    logic [31:0] stat_r;    // Registered status
    logic [31:0] stat_nxt;
    logic        dma_ok;    // DMA flags allowed

    // ------------------------------------------------------------------
    // Next status
    // ------------------------------------------------------------------
    always_comb begin
        dma_ok   = HAS_DMA & dma_en;
        stat_nxt = 32'h0000_0000;
        stat_nxt[`ALEVT_BIT_TX_FREE] = tx_free;
        stat_nxt[`ALEVT_BIT_TX_SENT] = tx_sent;
        stat_nxt[`ALEVT_BIT_RX_FULL] = rx_full;
        // Sticky, cleared by a read; a new event wins over the clear
        stat_nxt[`ALEVT_BIT_TX_STARVED] = (tx_starve & var_rate) |
            (stat_r[`ALEVT_BIT_TX_STARVED] & ~rd_clear);
        stat_nxt[`ALEVT_BIT_RX_OVER] = rx_over |
            (stat_r[`ALEVT_BIT_RX_OVER] & ~rd_clear);
        // Without DMA routing these flags are never raised
        stat_nxt[`ALEVT_BIT_RX_CNT_DONE] = rx_cnt_done & dma_ok;
        stat_nxt[`ALEVT_BIT_RX_BUFS_EX]  = rx_bufs_ex & dma_ok;
        stat_nxt[`ALEVT_BIT_TX_CNT_DONE] = tx_cnt_done & dma_ok;
        stat_nxt[`ALEVT_BIT_TX_BUFS_EX]  = tx_bufs_ex & dma_ok;
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_r <= 32'h0000_0000;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign status = stat_r;

endmodule : alevt_chan_flags

// ==== logic/alevt_top.sv ====
// Purpose: Event and interrupt logic of an audio codec serial link
// Assumes: All inputs synchronous to CORE_CLK, classic Wishbone access
// Notes:   Channel index 0 is the codec channel, 1 first, 2 second
//
// Notes on behaviour
// - DMA count flags only when routing enabled
// - Codec enable bits read back as written
// - Codec enables at bits 5,4,2,1,0
// - First-channel mode register holds transfer-count enables
// - Reading global status clears wake and frame
// - Bit 0 set by any frame start
// - Bit 1 set by codec input rising edge
// - Bit 2 while codec status AND enables
// - Bit 3 while first status AND mode
// - Bit 4 while second status AND mode
// - Set register writes ones into mask
// - Clear register writes ones out of mask
// - View register returns current mask
// - Holding-free and holding-full flags follow data path
// - Underrun needs variable rate; sticky flags clear on read
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "alevt_defs.svh"
module alevt_top
    import alevt_pkg::*;
(
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    // Link events
    input  wire logic        FRAME_START,
    input  wire logic        CODEC_SERIAL_IN,
    // Per-channel data path flags, index 0 codec, 1 first, 2 second
    input  wire logic [2:0]  TX_HOLDING_FREE,
    input  wire logic [2:0]  TX_ALL_SENT,
    input  wire logic [2:0]  TX_STARVED_EVT,
    input  wire logic [2:0]  RX_HOLDING_FULL,
    input  wire logic [2:0]  RX_OVERWRITTEN_EVT,
    // Transfer-count flags of the first channel
    input  wire logic        RX_COUNT_DONE,
    input  wire logic        RX_BUFFERS_EXHAUSTED,
    input  wire logic        TX_COUNT_DONE,
    input  wire logic        TX_BUFFERS_EXHAUSTED,
    // Controls to the data path
    output logic             DMA_ROUTE_ENABLE,
    output logic             VARIABLE_RATE_SELECT,
    // Interrupt request
    output logic             IRQ
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic        wr_go;              // Write strobe
    logic        rd_go;              // Read strobe
    logic [31:0] wmask;              // Byte-lane mask
    logic [31:0] rd_data;            // Read mux output
    alevt_reg_t  reg_sel;            // Decoded register
    logic [1:0]  chan_sel;           // Channel of a status/mode access
    logic [31:0] mode_r   [3];       // Enable/mode registers
    logic [31:0] mode_nxt [3];
    logic [31:0] stat_w   [3];       // Channel status words
    logic [2:0]  chan_evt;           // Per-channel event levels
    logic        sof_r;              // Frame seen since last read
    logic        sof_nxt;
    logic        wake_r;             // Wake seen since last read
    logic        wake_nxt;
    logic        ser_d_r;            // Previous codec input sample
    alevt_evt_t  mask_r;             // Interrupt mask
    alevt_evt_t  mask_nxt;
    alevt_evt_t  gstat;              // Global status
    logic        vrs_r;              // Variable-rate select
    logic        vrs_nxt;
    logic        irq_r;              // Registered request
    logic        wake_rise;          // Rising edge on codec input
    logic        gstat_rd;           // Global status being read
    logic [31:0] wdat;               // Write data after lanes

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    alevt_wb_slave u_bus (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .cyc     (WB_CYC_I),
        .stb     (WB_STB_I),
        .we      (WB_WE_I),
        .sel     (WB_SEL_I),
        .rd_data (rd_data),
        .ack     (WB_ACK_O),
        .dat_r   (WB_DAT_O),
        .wr_go   (wr_go),
        .rd_go   (rd_go),
        .wmask   (wmask)
    );

    assign wdat = WB_DAT_I & wmask;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Unlisted addresses decode to NONE: read zero, writes dropped
    always_comb begin
        reg_sel  = ALEVT_SEL_NONE;
        chan_sel = 2'h0;
        case (WB_ADR_I)
            `ALEVT_OFS_CODEC_STATUS:  reg_sel = ALEVT_SEL_STATUS;
            `ALEVT_OFS_CODEC_IRQ_EN:  reg_sel = ALEVT_SEL_MODE;
            `ALEVT_OFS_FIRST_STATUS: begin
                reg_sel  = ALEVT_SEL_STATUS;
                chan_sel = 2'h1;
            end
            `ALEVT_OFS_FIRST_MODE: begin
                reg_sel  = ALEVT_SEL_MODE;
                chan_sel = 2'h1;
            end
            `ALEVT_OFS_SECOND_STATUS: begin
                reg_sel  = ALEVT_SEL_STATUS;
                chan_sel = 2'h2;
            end
            `ALEVT_OFS_SECOND_MODE: begin
                reg_sel  = ALEVT_SEL_MODE;
                chan_sel = 2'h2;
            end
            `ALEVT_OFS_GLOBAL_STATUS: reg_sel = ALEVT_SEL_GLOBAL;
            `ALEVT_OFS_IRQ_SET:       reg_sel = ALEVT_SEL_SET;
            `ALEVT_OFS_IRQ_CLEAR:     reg_sel = ALEVT_SEL_CLEAR;
            `ALEVT_OFS_IRQ_VIEW:      reg_sel = ALEVT_SEL_VIEW;
            `ALEVT_OFS_CONTROL:       reg_sel = ALEVT_SEL_CONTROL;
            default:                  reg_sel = ALEVT_SEL_NONE;
        endcase
    end

    // ------------------------------------------------------------------
    // Channels: flags, enable registers and event levels
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            // Only the first channel has DMA-related mode bits
            localparam logic [31:0] WMASK_CH = (gi == 1) ?
                `ALEVT_MASK_FIRST_MODE : `ALEVT_MASK_BASIC_EN;
            logic rd_clr;   // Status read of this channel

            assign rd_clr = rd_go && (reg_sel == ALEVT_SEL_STATUS) &&
                            (chan_sel == 2'(gi));

            alevt_chan_flags #(
                .HAS_DMA (gi == 1)
            ) u_flags (
                .clk         (CORE_CLK),
                .rst_n       (RST_N),
                .tx_free     (TX_HOLDING_FREE[gi]),
                .tx_sent     (TX_ALL_SENT[gi]),
                .tx_starve   (TX_STARVED_EVT[gi]),
                .rx_full     (RX_HOLDING_FULL[gi]),
                .rx_over     (RX_OVERWRITTEN_EVT[gi]),
                .rx_cnt_done ((gi == 1) ? RX_COUNT_DONE : 1'b0),
                .rx_bufs_ex  ((gi == 1) ? RX_BUFFERS_EXHAUSTED : 1'b0),
                .tx_cnt_done ((gi == 1) ? TX_COUNT_DONE : 1'b0),
                .tx_bufs_ex  ((gi == 1) ? TX_BUFFERS_EXHAUSTED : 1'b0),
                .var_rate    (vrs_r),
                .dma_en      (mode_r[1][`ALEVT_BIT_DMA_ROUTE]),
                .rd_clear    (rd_clr),
                .status      (stat_w[gi])
            );

            // Enable bits take the written value, 1 on, 0 off
            always_comb begin
                mode_nxt[gi] = mode_r[gi];
                if (wr_go && (reg_sel == ALEVT_SEL_MODE) &&
                    (chan_sel == 2'(gi))) begin
                    mode_nxt[gi] = (mode_r[gi] & ~(wmask & WMASK_CH)) |
                                   (wdat & WMASK_CH);
                end
            end

            always_ff @(posedge CORE_CLK) begin
                if (!RST_N) begin
                    mode_r[gi] <= `ALEVT_RST_MODE;
                end else begin
                    mode_r[gi] <= mode_nxt[gi];
                end
            end

            // Level event, drops by itself when the cause goes away
            assign chan_evt[gi] = |(stat_w[gi] & mode_r[gi]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Global flags, mask and control
    // ------------------------------------------------------------------
    // Inputs are synchronous, so the wake edge is a one-sample compare
    assign wake_rise = CODEC_SERIAL_IN & ~ser_d_r;
    assign gstat_rd  = rd_go && (reg_sel == ALEVT_SEL_GLOBAL);
    assign gstat     = {chan_evt, wake_r, sof_r};

    always_comb begin
        // Set wins over the clear-on-read in the same cycle
        sof_nxt  = FRAME_START | (sof_r & ~gstat_rd);
        wake_nxt = wake_rise | (wake_r & ~gstat_rd);
        mask_nxt = mask_r;
        vrs_nxt  = vrs_r;
        if (wr_go) begin
            case (reg_sel)
                ALEVT_SEL_SET:
                    mask_nxt = mask_r | wdat[4:0];
                ALEVT_SEL_CLEAR:
                    mask_nxt = mask_r & ~wdat[4:0];
                ALEVT_SEL_CONTROL:
                    if (wmask[`ALEVT_BIT_VRS]) begin
                        vrs_nxt = WB_DAT_I[`ALEVT_BIT_VRS];
                    end
                default: begin
                    mask_nxt = mask_r;
                end
            endcase
        end
    end

    // Registers only; wake history starts high to avoid a false edge
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            sof_r   <= 1'b0;
            wake_r  <= 1'b0;
            ser_d_r <= 1'b1;
            mask_r  <= `ALEVT_RST_MASK;
            vrs_r   <= `ALEVT_RST_CONTROL;
            irq_r   <= 1'b0;
        end else begin
            sof_r   <= sof_nxt;
            wake_r  <= wake_nxt;
            ser_d_r <= CODEC_SERIAL_IN;
            mask_r  <= mask_nxt;
            vrs_r   <= vrs_nxt;
            irq_r   <= |(gstat & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Set and clear registers are write-only and read as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (reg_sel)
            ALEVT_SEL_STATUS:  rd_data = stat_w[chan_sel];
            ALEVT_SEL_MODE:    rd_data = mode_r[chan_sel];
            ALEVT_SEL_GLOBAL:  rd_data = {27'h0, gstat};
            ALEVT_SEL_VIEW:    rd_data = {27'h0, mask_r};
            ALEVT_SEL_CONTROL: rd_data = {31'h0, vrs_r};
            default:           rd_data = 32'h0000_0000;
        endcase
    end

    assign DMA_ROUTE_ENABLE     = mode_r[1][`ALEVT_BIT_DMA_ROUTE];
    assign VARIABLE_RATE_SELECT = vrs_r;
    assign IRQ                  = irq_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    AST_DMA_GATE: assert property (
        !DMA_ROUTE_ENABLE |=> (stat_w[1][15:14] == 2'h0) &&
                              (stat_w[1][11:10] == 2'h0))
        else $error("DMA flag raised without routing");
    AST_EN_READBACK: assert property (
        (wr_go && reg_sel == ALEVT_SEL_MODE && chan_sel == 2'h0 &&
         WB_SEL_I[0]) |=> (mode_r[0][7:0] == ($past(WB_DAT_I[7:0]) &
                           8'h37)))
        else $error("Codec enable readback wrong");
    AST_EN_TXFREE: assert property (
        (mode_r[0][0] && TX_HOLDING_FREE[0] && !wr_go) |=> gstat[2])
        else $error("Codec event missing");
    AST_MODE_RB: assert property (
        (wr_go && reg_sel == ALEVT_SEL_MODE && chan_sel == 2'h1 &&
         WB_SEL_I[1]) |=> (mode_r[1][15:8] == ($past(WB_DAT_I[15:8]) &
                           8'hcc)))
        else $error("First mode readback wrong");
    AST_RD_CLR: assert property (
        (gstat_rd && !FRAME_START && !wake_rise) |=> !sof_r && !wake_r)
        else $error("Status read did not clear");
    AST_SOF_SET: assert property (
        FRAME_START |=> sof_r ##1 (sof_r || $past(gstat_rd)))
        else $error("Frame flag lost");
    AST_WAKE_SET: assert property (
        ($rose(CODEC_SERIAL_IN) && $past(RST_N)) |=> wake_r)
        else $error("Wake flag not set");
    AST_FIRST_EVT: assert property (
        (RX_HOLDING_FULL[1] && mode_r[1][4] && !wr_go) |=> gstat[3])
        else $error("First channel event missing");
    AST_SECOND_EVT: assert property (
        (RX_HOLDING_FULL[2] && mode_r[2][4] && !wr_go) |=> gstat[4])
        else $error("Second channel event missing");
    AST_MASK_SET: assert property (
        (wr_go && reg_sel == ALEVT_SEL_SET && WB_SEL_I[0]) |=>
        (mask_r == ($past(mask_r) | $past(WB_DAT_I[4:0]))))
        else $error("Mask set wrong");
    AST_MASK_CLR: assert property (
        (wr_go && reg_sel == ALEVT_SEL_CLEAR && WB_SEL_I[0]) |=>
        (mask_r == ($past(mask_r) & ~$past(WB_DAT_I[4:0]))))
        else $error("Mask clear wrong");
    AST_STARVE_VRS: assert property (
        (!vrs_r && !stat_w[1][2]) |=> !stat_w[1][2])
        else $error("Underrun without variable rate");
    AST_IRQ: assert property (
        IRQ == $past(|(gstat & mask_r)))
        else $error("Interrupt request does not follow status");

    COV_SOF_READ:  cover property (sof_r ##1 gstat_rd ##1 !sof_r);
    COV_WAKE_IRQ:  cover property (wake_r && mask_r[1] ##1 IRQ);
    COV_FIRST_EVT: cover property ($rose(gstat[3]));
    COV_MASK_OFF:  cover property (IRQ ##1 (wr_go &&
                                   reg_sel == ALEVT_SEL_CLEAR));

endmodule : alevt_top

// ==== sim/alevt_codec_model.sv ====
// Purpose: Codec side of the link: frame starts and wake line
// Assumes: One frame start every 16 cycles of run
// Notes:   Serial line follows wake one edge later
`timescale 1ns/10ps
module alevt_codec_model (
    // Commands from the bench
    input  wire logic clk,
    input  wire logic run,
    input  wire logic wake,
    // Link lines
    output logic      frame_start = 1'b0,
    output logic      serial_in = 1'b0
);
    logic [3:0] cnt_r = 4'h0;  // Frame slot counter
    // Frame pulse only while running, so a stopped link stays quiet
    always_ff @(posedge clk) begin
        cnt_r <= run ? cnt_r + 4'h1 : 4'h0;
        frame_start <= run && cnt_r == 4'hf;
        serial_in <= wake;
    end
endmodule : alevt_codec_model

// ==== sim/testbench.sv ====
// Purpose: Register level checks of the event block
// Assumes: One wait state per bus access
// Notes:   Sticky channel inputs are driven as single-cycle pulses
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic run = 1'b0, wake = 1'b0, cnt = 1'b0, sof, ser, ack, irq, dma;
    logic vrs;
    logic [2:0]  stv = 3'h0, ovr = 3'h0;  // Underrun and overrun pulses
    logic [3:0]  sel = 4'hf;              // Write byte lanes
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, dout, q;
    logic [8:0]  lv = 9'h0;  // Level flags: free, sent, full per channel
    int err_count = 0, comparisons = 0, bp;
    always #25 clk = ~clk;
    alevt_codec_model alevt_codec_model_i (.clk(clk), .run(run),
        .wake(wake), .frame_start(sof), .serial_in(ser));
    alevt_top alevt_top_i (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack),
        .FRAME_START(sof), .CODEC_SERIAL_IN(ser),
        .TX_HOLDING_FREE(lv[2:0]), .TX_ALL_SENT(lv[5:3]),
        .TX_STARVED_EVT(stv), .RX_HOLDING_FULL(lv[8:6]),
        .RX_OVERWRITTEN_EVT(ovr), .RX_COUNT_DONE(cnt),
        .RX_BUFFERS_EXHAUSTED(cnt), .TX_COUNT_DONE(cnt),
        .TX_BUFFERS_EXHAUSTED(cnt), .DMA_ROUTE_ENABLE(dma),
        .VARIABLE_RATE_SELECT(vrs), .IRQ(irq));
    // Classic single cycle, held until ack is sampled
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : acc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // Hang guard, well past the expected run length
    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h24, 32'h0);
        acc(1'b1, 8'h1c, 32'hffff_ffff);
        rd(8'h24, 32'h1f);
        acc(1'b1, 8'h20, 32'h0000_0005);
        rd(8'h24, 32'h1a);
        // Lane 0 off: the set write must not reach the mask
        sel <= 4'h2;
        acc(1'b1, 8'h1c, 32'h0000_001f);
        sel <= 4'hf;
        rd(8'h24, 32'h1a);
        acc(1'b1, 8'h04, 32'hffff_ffff);
        rd(8'h04, 32'h37);
        // Each level flag of each channel, alone, through its enable
        for (int j = 0; j < 9; j++) begin
            bp = (j / 3 == 2) ? 4 : j / 3;
            acc(1'b1, 8'(4 + 8 * (j % 3)), 32'h1 << bp);
            lv[j] <= 1'b1;
            repeat (3) @(posedge clk);
            chk(irq, j % 3 != 0);
            rd(8'(8 * (j % 3)), 32'h1 << bp);
            rd(8'h18, 32'h4 << (j % 3));
            lv[j] <= 1'b0;
            acc(1'b1, 8'(4 + 8 * (j % 3)), 32'h0);
            rd(8'h18, 32'h0);
        end
        // Count flags hidden until routing is on
        acc(1'b1, 8'h0c, 32'h0000_4000);
        cnt <= 1'b1;
        repeat (2) @(posedge clk);
        rd(8'h08, 32'h0);
        acc(1'b1, 8'h0c, 32'h0040_4000);
        repeat (2) @(posedge clk);
        chk(dma, 1'b1);
        rd(8'h08, 32'hcc00);
        rd(8'h18, 32'h8);
        cnt <= 1'b0;
        acc(1'b1, 8'h0c, 32'h0);
        // Sticky flags: underrun only with variable rate, cleared per read
        stv <= 3'h7;
        @(posedge clk);
        stv <= 3'h0;
        rd(8'h00, 32'h0);
        acc(1'b1, 8'h28, 32'h1);
        chk(vrs, 1'b1);
        stv <= 3'h7;
        ovr <= 3'h7;
        @(posedge clk);
        stv <= 3'h0;
        ovr <= 3'h0;
        rd(8'h08, 32'h24);
        rd(8'h08, 32'h0);
        rd(8'h00, 32'h24);
        run <= 1'b1;
        repeat (20) @(posedge clk);
        run <= 1'b0;
        rd(8'h18, 32'h1);
        rd(8'h18, 32'h0);
        wake <= 1'b1;
        repeat (4) @(posedge clk);
        chk(irq, 1'b1);
        rd(8'h18, 32'h2);
        rd(8'h18, 32'h0);
        tally_and_finish;
    end
endmodule : testbench
